// *** pfcpl_top.sv ***
// pfc current protection, mode detection and gate control with an apb register file
// assumes comparator levels are asynchronous; gate_request, high_line, multiplier
// and control words come from logic on ref_clk
//
// The address map and the APB register port are this design's own decisions.
module pfcpl_top #(
    parameter int unsigned DATA_W            = 12,
    parameter int unsigned LOCKOUT_CYCLES    = pfcpl_pkg::LOCKOUT_CYCLES,
    parameter int unsigned EXIT_BLANK_CYCLES = pfcpl_pkg::EXIT_BLANK_CYCLES
) (
    input  wire logic                        ref_clk,
    input  wire logic                        srst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [pfcpl_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        cmp_ref_high,
    input  wire logic                        cmp_ref_low,
    input  wire logic                        cmp_cycle_limit,
    input  wire logic                        cmp_overstress,
    input  wire logic                        cmp_low_current,
    input  wire logic                        gate_request,
    input  wire logic                        high_line,
    input  wire logic [DATA_W-1:0]           multiplier_voltage,
    input  wire logic [DATA_W-1:0]           loop_control_signal,
    output logic                             gate_drive_out,
    output logic      [DATA_W-1:0]           regulation_level,
    output logic                             ccm_active,
    output logic                             cycle_overcurrent_trip,
    output logic                             overstress_fault,
    output logic                             low_current_flag,
    output logic                             irq
);
    import pfcpl_pkg::*;

    localparam int unsigned BLANK_W = $clog2(EXIT_BLANK_CYCLES + 1);

    logic [4:0]        cmp_sync;
    logic              lockout;
    logic [1:0]        ctrl_reg;
    logic [RAMP_W-1:0] period_reg;
    logic [RAMP_W-1:0] osc_upper_reg;
    logic [IRQ_W-1:0]  irq_stat_reg;
    logic [IRQ_W-1:0]  irq_mask_reg;
    pfcpl_gate_t       gate_state_reg;
    pfcpl_gate_t       gate_next;
    logic              gate_on_reg;
    logic [RAMP_W-1:0] ramp_reg;
    logic [RAMP_W-1:0] cyc_len_reg;
    logic              seen_valid_reg;
    logic [3:0]        run_cnt_reg;
    logic [BLANK_W-1:0] blank_cnt_reg;
    logic              lockout_d_reg;

    // comparator bundle: 0 ref high, 1 ref low, 2 cycle limit, 3 overstress, 4 low current
    pfcpl_sync #(.W(5)) u_sync (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .async_in ({cmp_low_current, cmp_overstress, cmp_cycle_limit, cmp_ref_low,
                    cmp_ref_high}),
        .sync_out (cmp_sync)
    );

    wire above_high_s = cmp_sync[0];
    wire above_low_s  = cmp_sync[1];
    wire ocp_s        = cmp_sync[2];
    wire ovs_s        = cmp_sync[3];
    wire low_cur_s    = cmp_sync[4];

    pfcpl_lockout #(.HOLD_CYCLES(LOCKOUT_CYCLES)) u_lockout (
        .ref_clk        (ref_clk),
        .srst           (srst),
        .overstress_hit (ovs_s),
        .current_low    (low_cur_s),
        .lockout        (lockout)
    );

    // gate sequencing
    wire holdoff_en   = ctrl_reg[CTRL_HOLDOFF_BIT];
    wire lowline_only = ctrl_reg[CTRL_LOWLINE_ONLY];
    wire [RAMP_W:0] ramp_sum = {1'b0, {(RAMP_W - DATA_W){1'b0}}, multiplier_voltage}
                             + {1'b0, ramp_reg};
    wire ramp_end     = ramp_sum >= {1'b0, osc_upper_reg};
    wire holdoff_ok   = ccm_active || !holdoff_en || low_cur_s;
    wire turn_on_ok   = gate_request && !lockout && !ovs_s && !ocp_s && holdoff_ok;
    wire on_time_end  = ccm_active ? ramp_end : !gate_request;
    wire gate_stop    = lockout || ovs_s || ocp_s || on_time_end;
    wire cycle_start  = (gate_state_reg == GATE_OFF) && turn_on_ok;
    wire ocp_event    = (gate_state_reg == GATE_ON) && ocp_s;

    always_comb
    begin
        gate_next = gate_state_reg;
        case (gate_state_reg)
            GATE_OFF:          gate_next = turn_on_ok ? GATE_ON : GATE_OFF;
            GATE_ON:           gate_next = gate_stop ? GATE_WAIT_RELEASE : GATE_ON;
            GATE_WAIT_RELEASE: gate_next = gate_request ? GATE_WAIT_RELEASE : GATE_OFF;
            default:           gate_next = GATE_OFF;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            gate_state_reg <= GATE_OFF;
            gate_on_reg    <= 1'b0;
        end
        else
        begin
            gate_state_reg <= gate_next;
            gate_on_reg    <= (gate_next == GATE_ON);
        end
    end

    // raw limit comparator cuts the pulse without a clock edge
    assign gate_drive_out = gate_on_reg && !cmp_cycle_limit;

    // ramp and cycle length
    always_ff @(posedge ref_clk)
    begin
        if (srst || cycle_start)
        begin
            ramp_reg    <= '0;
            cyc_len_reg <= '0;
        end
        else
        begin
            if (gate_state_reg == GATE_ON && ramp_reg != '1)
                ramp_reg <= ramp_reg + RAMP_W'(1);
            if (cyc_len_reg != '1)
                cyc_len_reg <= cyc_len_reg + RAMP_W'(1);
        end
    end

    // current criterion per cycle with hysteretic reference
    wire cur_above = ccm_active ? above_low_s : above_high_s;
    always_ff @(posedge ref_clk)
    begin
        if (srst || cycle_start)
            seen_valid_reg <= 1'b0;
        else if (cur_above)
            seen_valid_reg <= 1'b1;
    end

    // mode detection
    wire [31:0] entry_prod   = 32'(period_reg) * 32'(CCM_ENTRY_PCT);
    wire [31:0] entry_thresh = entry_prod / 32'(PCT_BASE);
    wire entry_long  = {16'h0000, cyc_len_reg} >= entry_thresh;
    wire exit_long   = cyc_len_reg >= period_reg;
    wire bypass_cur  = lowline_only && high_line;
    wire valid_cycle = entry_long && (seen_valid_reg || bypass_cur);
    wire run_hit     = ccm_active ? exit_long : valid_cycle;
    wire run_full    = run_hit && (run_cnt_reg == 4'(CCM_CYCLE_COUNT - 1));
    wire blank_done  = ccm_active && (blank_cnt_reg == BLANK_W'(EXIT_BLANK_CYCLES - 1));
    wire ccm_enter   = cycle_start && !ccm_active && run_full;
    wire ccm_leave   = blank_done;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            run_cnt_reg <= '0;
        else if (ccm_enter || ccm_leave)
            run_cnt_reg <= '0;
        else if (cycle_start)
            run_cnt_reg <= (run_hit && !run_full) ? run_cnt_reg + 4'(1) : 4'(0);
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ccm_active    <= 1'b0;
            blank_cnt_reg <= '0;
        end
        else
        begin
            if (ccm_enter)
                ccm_active <= 1'b1;
            else if (ccm_leave)
                ccm_active <= 1'b0;
            if (!ccm_active || (cycle_start && run_full))
                blank_cnt_reg <= '0;
            else if (!blank_done)
                blank_cnt_reg <= blank_cnt_reg + BLANK_W'(1);
        end
    end

    // regulation level and flags
    wire [DATA_W-1:0] reg_level_next = (ccm_active && high_line)
                                     ? (loop_control_signal >> HIGH_LINE_SHIFT)
                                     : loop_control_signal;
    wire [IRQ_W-1:0] irq_set;
    assign irq_set[IRQ_OCP_BIT]     = ocp_event;
    assign irq_set[IRQ_OVS_BIT]     = lockout && !lockout_d_reg;
    assign irq_set[IRQ_CCM_ON_BIT]  = ccm_enter;
    assign irq_set[IRQ_CCM_OFF_BIT] = ccm_leave;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            regulation_level       <= '0;
            cycle_overcurrent_trip <= 1'b0;
            overstress_fault       <= 1'b0;
            low_current_flag       <= 1'b0;
            lockout_d_reg          <= 1'b0;
        end
        else
        begin
            regulation_level       <= reg_level_next;
            cycle_overcurrent_trip <= ocp_event;
            overstress_fault       <= lockout;
            low_current_flag       <= low_cur_s;
            lockout_d_reg          <= lockout;
        end
    end

    // apb slave: one wait state, answer in the third cycle of a transfer
    wire access     = psel && penable;
    wire complete   = access && pready;
    wire hit_ctrl   = (paddr == OFS_CTRL);
    wire hit_period = (paddr == OFS_PERIOD);
    wire hit_upper  = (paddr == OFS_OSC_UPPER);
    wire hit_status = (paddr == OFS_STATUS);
    wire hit_istat  = (paddr == OFS_IRQ_STAT);
    wire hit_imask  = (paddr == OFS_IRQ_MASK);
    wire addr_hit   = hit_ctrl | hit_period | hit_upper | hit_status | hit_istat | hit_imask;
    wire wr_en      = complete && pwrite;
    wire istat_clr  = complete && !pwrite && hit_istat;
    // clears only the bits that the read returned
    wire [IRQ_W-1:0] istat_clr_mask = istat_clr ? prdata[IRQ_W-1:0] : '0;
    wire [4:0] status_word = {gate_on_reg, high_line, low_cur_s, lockout, ccm_active};
    wire [31:0] rd_mux = hit_ctrl   ? {30'h0, ctrl_reg}
                       : hit_period ? {16'h0, period_reg}
                       : hit_upper  ? {16'h0, osc_upper_reg}
                       : hit_status ? {27'h0, status_word}
                       : hit_istat  ? {28'h0, irq_stat_reg}
                       : hit_imask  ? {28'h0, irq_mask_reg}
                       : 32'h0;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= access && !pready;
            pslverr <= access && !pready && !addr_hit;
            prdata  <= (access && !pready && !pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ctrl_reg      <= CTRL_RST;
            period_reg    <= PERIOD_RST;
            osc_upper_reg <= OSC_UPPER_RST;
            irq_mask_reg  <= IRQ_MASK_RST;
        end
        else if (wr_en)
        begin
            if (hit_ctrl)
                ctrl_reg <= pwdata[1:0];
            if (hit_period)
                period_reg <= pwdata[RAMP_W-1:0];
            if (hit_upper)
                osc_upper_reg <= pwdata[RAMP_W-1:0];
            if (hit_imask)
                irq_mask_reg <= pwdata[IRQ_W-1:0];
        end
    end

    // sticky events, read clears, a new event wins over the clear
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            irq_stat_reg <= '0;
            irq          <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= (irq_stat_reg & ~istat_clr_mask) | irq_set;
            irq          <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    property p_ocp_cut;
        @(posedge ref_clk) disable iff (srst)
        cmp_cycle_limit |-> !gate_drive_out;
    endproperty
    a_ocp_cut: assert property (p_ocp_cut)
        else $error("gate high while cycle limit active");

    property p_sync_ocp;
        @(posedge ref_clk) disable iff (srst)
        (gate_state_reg == GATE_ON && cmp_cycle_limit) [*3] |=> gate_state_reg != GATE_ON;
    endproperty
    a_sync_ocp: assert property (p_sync_ocp)
        else $error("synchronised limit did not end on state");

    property p_lock_gate;
        @(posedge ref_clk) disable iff (srst)
        lockout |=> !gate_on_reg;
    endproperty
    a_lock_gate: assert property (p_lock_gate)
        else $error("gate driven during overstress lockout");

    property p_holdoff;
        @(posedge ref_clk) disable iff (srst)
        (cycle_start && !ccm_active && holdoff_en) |-> low_cur_s;
    endproperty
    a_holdoff: assert property (p_holdoff)
        else $error("turn-on without low current in hold-off mode");

    property p_low_flag;
        @(posedge ref_clk) disable iff (srst)
        ##1 low_current_flag == $past(cmp_sync[4]);
    endproperty
    a_low_flag: assert property (p_low_flag)
        else $error("low current flag does not follow comparator");

    property p_ramp_end;
        @(posedge ref_clk) disable iff (srst)
        (ccm_active && gate_state_reg == GATE_ON && ramp_end) |=> gate_state_reg != GATE_ON;
    endproperty
    a_ramp_end: assert property (p_ramp_end)
        else $error("ccm on-time did not end at ramp threshold");

    property p_reg_level;
        @(posedge ref_clk) disable iff (srst)
        $past(ccm_active && high_line) |->
            regulation_level == ($past(loop_control_signal) >> HIGH_LINE_SHIFT);
    endproperty
    a_reg_level: assert property (p_reg_level)
        else $error("regulation level not divided by 4");

    property p_invalid_resets;
        @(posedge ref_clk) disable iff (srst)
        (cycle_start && !ccm_active && !seen_valid_reg && !bypass_cur) |=> run_cnt_reg == 4'h0;
    endproperty
    a_invalid_resets: assert property (p_invalid_resets)
        else $error("unvalidated cycle counted toward entry");

    property p_ref_sel;
        @(posedge ref_clk) disable iff (srst)
        (ccm_active && !cycle_start && !above_low_s && !seen_valid_reg) |=> !seen_valid_reg;
    endproperty
    a_ref_sel: assert property (p_ref_sel)
        else $error("wrong minimum reference used in ccm");

    property p_ref_low_ccm;
        @(posedge ref_clk) disable iff (srst)
        (ccm_active && !cycle_start && above_low_s) |=> seen_valid_reg;
    endproperty
    a_ref_low_ccm: assert property (p_ref_low_ccm)
        else $error("low reference ignored in ccm");

    property p_entry;
        @(posedge ref_clk) disable iff (srst)
        $rose(ccm_active) |-> $past(run_cnt_reg) == 4'(CCM_CYCLE_COUNT - 1);
    endproperty
    a_entry: assert property (p_entry)
        else $error("ccm entered without eight cycles");

    property p_exit;
        @(posedge ref_clk) disable iff (srst)
        $fell(ccm_active) |-> $past(blank_cnt_reg) == BLANK_W'(EXIT_BLANK_CYCLES - 1);
    endproperty
    a_exit: assert property (p_exit)
        else $error("ccm left before blanking elapsed");
endmodule : pfcpl_top

// *** pfcpl_pkg.sv ***
// constants, register map and state types of the pfc current protection logic
// assumes a single 250 MHz controller clock with synchronous reset
package pfcpl_pkg;

    localparam int unsigned CLK_HZ            = 250_000_000;
    localparam int unsigned LOCKOUT_US        = 800;
    localparam int unsigned LOCKOUT_CYCLES    = LOCKOUT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned EXIT_BLANK_MS     = 360;
    localparam int unsigned EXIT_BLANK_CYCLES = EXIT_BLANK_MS * (CLK_HZ / 1_000);

    localparam int unsigned CCM_CYCLE_COUNT   = 8;
    localparam int unsigned CCM_ENTRY_PCT     = 112;
    localparam int unsigned PCT_BASE          = 100;
    localparam int unsigned HIGH_LINE_SHIFT   = 2;

    localparam int unsigned RAMP_W            = 16;
    localparam int unsigned ADDR_W            = 8;
    localparam int unsigned IRQ_W             = 4;

    localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PERIOD    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_OSC_UPPER = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h14;

    localparam int unsigned CTRL_HOLDOFF_BIT    = 0;
    localparam int unsigned CTRL_LOWLINE_ONLY   = 1;
    localparam int unsigned IRQ_OCP_BIT         = 0;
    localparam int unsigned IRQ_OVS_BIT         = 1;
    localparam int unsigned IRQ_CCM_ON_BIT      = 2;
    localparam int unsigned IRQ_CCM_OFF_BIT     = 3;

    localparam logic [1:0]        CTRL_RST      = 2'h1;
    localparam logic [RAMP_W-1:0] PERIOD_RST    = 16'h0F06;
    localparam logic [RAMP_W-1:0] OSC_UPPER_RST = 16'h0FFF;
    localparam logic [IRQ_W-1:0]  IRQ_MASK_RST  = 4'h0;

    typedef enum logic [1:0] {GATE_OFF, GATE_ON, GATE_WAIT_RELEASE} pfcpl_gate_t;
    typedef enum logic [1:0] {LK_IDLE, LK_WAIT_LOW, LK_COUNT} pfcpl_lock_t;

endpackage : pfcpl_pkg

// *** pfcpl_sync.sv ***
// two flip-flop synchroniser for a bundle of independent comparator levels
// assumes each bit is a slow level; no word coherence is implied
module pfcpl_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : pfcpl_sync

// *** pfcpl_lockout.sv ***
// overstress lockout timer: waits for low current, then holds for a fixed count
// assumes synchronised inputs on ref_clk
module pfcpl_lockout #(
    parameter int unsigned HOLD_CYCLES = 200000
) (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic overstress_hit,
    input  wire logic current_low,
    output logic      lockout
);
    import pfcpl_pkg::*;

    localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);

    pfcpl_lock_t      state_reg;
    logic [CNT_W-1:0] cnt_reg;
    wire              hold_done = (cnt_reg == CNT_W'(HOLD_CYCLES - 1));

    assign lockout = (state_reg != LK_IDLE);

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_reg <= LK_IDLE;
            cnt_reg   <= '0;
        end
        else if (overstress_hit)
        begin
            state_reg <= LK_WAIT_LOW;
            cnt_reg   <= '0;
        end
        else
        begin
            case (state_reg)
                LK_WAIT_LOW:
                begin
                    cnt_reg <= '0;
                    if (current_low)
                        state_reg <= LK_COUNT;
                end
                LK_COUNT:
                begin
                    cnt_reg <= cnt_reg + CNT_W'(1);
                    if (hold_done)
                        state_reg <= LK_IDLE;
                end
                default:
                begin
                    state_reg <= LK_IDLE;
                    cnt_reg   <= '0;
                end
            endcase
        end
    end

    property p_ovs_restart;
        @(posedge ref_clk) disable iff (srst)
        overstress_hit |=> (state_reg == LK_WAIT_LOW) && (cnt_reg == '0);
    endproperty
    a_ovs_restart: assert property (p_ovs_restart)
        else $error("overstress did not restart lockout");

    property p_hold_full;
        @(posedge ref_clk) disable iff (srst)
        $fell(lockout) |-> $past(cnt_reg) == CNT_W'(HOLD_CYCLES - 1);
    endproperty
    a_hold_full: assert property (p_hold_full)
        else $error("lockout ended before full hold count");
endmodule : pfcpl_lockout

// *** pfcpl_far_model.sv ***
// behavioural inductor current and comparator bank facing the gate drive
// assumes gate_drive_out from the block; surge forces a current spike
module pfcpl_far_model (
    input  wire logic ref_clk,
    input  wire logic gate_drive_out,
    input  wire logic surge,
    output logic      cmp_ref_high,
    output logic      cmp_ref_low,
    output logic      cmp_cycle_limit,
    output logic      cmp_overstress,
    output logic      cmp_low_current
);
    timeunit 1ns;
    timeprecision 1ps;
    int cur = 0;
    // current rises while the switch conducts and decays while it is open
    always @(posedge ref_clk)
    begin
        if (surge)
            cur <= 320;
        else if (gate_drive_out === 1'b1)
            cur <= cur + 5;
        else
            cur <= (cur > 8) ? cur - 8 : 0;
    end
    assign cmp_ref_high    = (cur > 50);
    assign cmp_ref_low     = (cur > 30);
    assign cmp_cycle_limit = (cur > 200);
    assign cmp_overstress  = (cur > 300);
    assign cmp_low_current = (cur < 10);
endmodule : pfcpl_far_model

// *** tb.sv ***
// self-checking bench for the pfc current protection block
// assumes the far model closes the current loop; short lockout and blanking counts
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pfcpl_pkg::*;
    logic        ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, e, gate_request = 0, high_line = 0, surge = 0;
    logic [11:0] multiplier_voltage = 12'h000, loop_control_signal = 12'h000, c;
    logic        cmp_ref_high, cmp_ref_low, cmp_cycle_limit, cmp_overstress;
    logic        cmp_low_current, gate_drive_out, ccm_active, cycle_overcurrent_trip;
    logic        overstress_fault, low_current_flag, irq, seen;
    logic [11:0] regulation_level;
    int          miscompares = 0, cmp_count = 0, cyc = 0, n, on, m;
    logic [7:0]  adr [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h20};
    logic [31:0] rst [5] = '{32'h1, 32'h0F06, 32'h0FFF, 32'h0, 32'h0};
    pfcpl_top #(.LOCKOUT_CYCLES(20), .EXIT_BLANK_CYCLES(400)) dut (
        .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_ref_high(cmp_ref_high), .cmp_ref_low(cmp_ref_low),
        .cmp_cycle_limit(cmp_cycle_limit), .cmp_overstress(cmp_overstress),
        .cmp_low_current(cmp_low_current), .gate_request(gate_request),
        .high_line(high_line), .multiplier_voltage(multiplier_voltage),
        .loop_control_signal(loop_control_signal), .gate_drive_out(gate_drive_out),
        .regulation_level(regulation_level), .ccm_active(ccm_active),
        .cycle_overcurrent_trip(cycle_overcurrent_trip),
        .overstress_fault(overstress_fault), .low_current_flag(low_current_flag),
        .irq(irq));
    pfcpl_far_model far (.ref_clk(ref_clk), .gate_drive_out(gate_drive_out),
        .surge(surge), .cmp_ref_high(cmp_ref_high), .cmp_ref_low(cmp_ref_low),
        .cmp_cycle_limit(cmp_cycle_limit), .cmp_overstress(cmp_overstress),
        .cmp_low_current(cmp_low_current));
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, got, exp);
        end
    endtask : chk
    task print_verdict;
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    function automatic logic [11:0] exp_reg(logic [11:0] v, logic hl, logic ccm);
        return (ccm && hl) ? (v >> 2) : v;
    endfunction : exp_reg
    task wait_low;
        for (n = 0; n < 100 && low_current_flag !== 1'b1; n++) @(posedge ref_clk);
    endtask : wait_low
    task set_ctl(input logic hl, input logic ccm);
        c = 12'($urandom);
        loop_control_signal <= c; high_line <= hl;
        repeat (3) @(posedge ref_clk);
        chk(regulation_level, exp_reg(c, hl, ccm));
    endtask : set_ctl
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc >= 20000)
        begin
            miscompares++;
            print_verdict;
        end
    end
    always @(negedge ref_clk)
        if (cmp_cycle_limit === 1'b1 && srst === 1'b0) chk(gate_drive_out, 0);
    initial
    begin
        void'($urandom(16288));
        repeat (8) @(posedge ref_clk);
        srst <= 0;
        repeat (4) @(posedge ref_clk);
        chk(low_current_flag, 1);
        for (int i = 0; i < 5; i++)
        begin
            apb(0, adr[i], 32'h0);
            chk(q, rst[i]);
            chk(e, adr[i] == 8'h20);
        end
        apb(1, OFS_IRQ_MASK, 32'hF);
        repeat (6) set_ctl(1'($urandom), 0);
        apb(0, OFS_IRQ_STAT, 0);
        gate_request <= 1;
        repeat (10) @(posedge ref_clk);
        surge <= 1;
        @(posedge ref_clk);
        surge <= 0;
        repeat (6) @(posedge ref_clk);
        chk({overstress_fault, irq}, 2'b11);
        apb(0, OFS_IRQ_STAT, 0);
        chk(q[IRQ_OVS_BIT], 1);
        repeat (3) @(posedge ref_clk);
        chk(irq, 0);
        wait_low;
        repeat (10) @(posedge ref_clk);
        surge <= 1;
        @(posedge ref_clk);
        surge <= 0;
        gate_request <= 0;
        repeat (4) @(posedge ref_clk);
        gate_request <= 1;
        wait_low;
        on = 0;
        repeat (18) @(posedge ref_clk) on += gate_drive_out;
        chk(on, 0);
        seen = 0;
        repeat (80) @(posedge ref_clk) seen |= cycle_overcurrent_trip;
        chk(seen, 1);
        gate_request <= 0;
        repeat (40) @(posedge ref_clk);
        apb(1, OFS_PERIOD, 32'd20);
        apb(1, OFS_OSC_UPPER, 32'd10);
        repeat (12)
        begin
            gate_request <= 1;
            repeat (15 + $urandom_range(2)) @(posedge ref_clk);
            gate_request <= 0;
            repeat (15) @(posedge ref_clk);
        end
        chk(ccm_active, 1);
        set_ctl(1, 1);
        m = $urandom_range(4);
        multiplier_voltage <= 12'(m);
        gate_request <= 1;
        on = 0;
        repeat (15) @(posedge ref_clk) on += gate_drive_out;
        chk(on, 10 + 1 - m);
        gate_request <= 0;
        repeat (400) @(posedge ref_clk);
        chk(ccm_active, 0);
        apb(0, OFS_IRQ_STAT, 0);
        chk(q[3:2], 2'b11);
        print_verdict;
    end
endmodule : tb
